// ### hdl/cgr_top.sv
// clock guard, backup clock, reset flags, prescaler and clock out
`timescale 1ns/1ps
`include "cgr_cfg.svh"
module cgr_top (
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // axi4-lite write address
   input wire logic [9:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   // axi4-lite write data
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   // axi4-lite write response
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // axi4-lite read address
   input wire logic [9:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   // axi4-lite read data
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // oscillator and option straps
   input wire logic osc_in,
   input wire logic opt_guard_en,
   input wire logic opt_uv_en,
   // core state
   input wire logic halt_mode,
   input wire logic wait_mode,
   input wire logic irq_mask,
   // reset events, one-cycle pulses
   input wire logic rst_ev_uv,
   input wire logic rst_ev_wdg,
   input wire logic rst_ev_ext,
   // clock and event outputs
   output logic src_clk_q,
   output logic cpu_clk_q,
   output logic clk_out_q,
   output logic backup_sel_q,
   output logic guard_irq_q,
   output logic wait_wake_q
);

   logic guard_en_q;
   logic uv_en_q;
   logic strap_done_q;
   logic flt_lvl_q;
   logic flt_prev_q;
   logic [7:0] run_q;
   logic [7:0] idle_q;
   logic [3:0] good_q;
   logic [7:0] bak_cnt_q;
   logic bak_lvl_q;
   logic sel_d;
   logic src_prev_q;
   logic [3:0] pre_cnt_q;
   logic [4:0] half_m1;
   logic cpu_d;
   logic flt_edge;
   logic loss;
   logic want_bak;
   logic rst_any;
   cgr_pkg::cgr_guard_t guard_q;
   // status and control fields
   logic irq_en_q;
   logic bflag_q;
   logic uv_flag_q;
   logic wdg_flag_q;
   logic sms_q;
   logic [1:0] dsel_q;
   logic cko_en_q;
   logic [7:0] status_byte;
   logic [7:0] misc_byte;
   // bus state
   logic aw_full_q;
   logic w_full_q;
   logic [9:0] aw_addr_q;
   logic [31:0] w_data_q;
   logic [3:0] w_strb_q;
   logic wr_go;
   logic wr_st;
   logic wr_misc;
   logic rd_hs;
   logic rd_clr;
   logic rd_st_q;

   assign rst_any = rst_ev_uv | rst_ev_wdg | rst_ev_ext;

   // straps are caught once after reset release
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         guard_en_q <= 1'b0;
         uv_en_q <= 1'b0;
         strap_done_q <= 1'b0;
      end else if (!strap_done_q) begin
         guard_en_q <= opt_guard_en;
         uv_en_q <= opt_uv_en;
         strap_done_q <= 1'b1;
      end
   end

   // level must hold before it passes
   // harmonic clock never settles, so is blocked
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         flt_lvl_q <= 1'b0;
         run_q <= 8'h00;
      end else if (!guard_en_q) begin
         flt_lvl_q <= osc_in;
         run_q <= 8'h00;
      end else if (!halt_mode) begin
         if (osc_in == flt_lvl_q) begin
            run_q <= 8'h00;
         end else if (run_q == 8'(`CGR_FILT_CYC - 1)) begin
            flt_lvl_q <= osc_in;
            run_q <= 8'h00;
         end else begin
            run_q <= run_q + 8'h01;
         end
      end
   end

   assign flt_edge = flt_lvl_q != flt_prev_q;
   assign loss = idle_q == 8'(`CGR_LOSS_CYC);

   // idle counter saturates, so loss stays flagged
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         flt_prev_q <= 1'b0;
         idle_q <= 8'h00;
      end else if (!halt_mode) begin
         flt_prev_q <= flt_lvl_q;
         if (flt_edge) begin
            idle_q <= 8'h00;
         end else if (!loss) begin
            idle_q <= idle_q + 8'h01;
         end
      end
   end

   // enough good edges return to main
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         guard_q <= cgr_pkg::G_MAIN;
         good_q <= 4'h0;
      end else if (!guard_en_q) begin
         guard_q <= cgr_pkg::G_MAIN;
         good_q <= 4'h0;
      end else if (!halt_mode) begin
         unique case (guard_q)
            cgr_pkg::G_MAIN: begin
               if (loss) begin
                  guard_q <= cgr_pkg::G_BACKUP;
               end
            end
            cgr_pkg::G_BACKUP: begin
               if (flt_edge) begin
                  guard_q <= cgr_pkg::G_RECOVER;
                  good_q <= 4'h0;
               end
            end
            cgr_pkg::G_RECOVER: begin
               if (loss) begin
                  guard_q <= cgr_pkg::G_BACKUP;
               end else if (flt_edge) begin
                  if (good_q == 4'(`CGR_RECOV_EDGES - 1)) begin
                     guard_q <= cgr_pkg::G_MAIN;
                  end else begin
                     good_q <= good_q + 4'h1;
                  end
               end
            end
            default: begin
               guard_q <= cgr_pkg::G_MAIN;
            end
         endcase
      end
   end

   assign want_bak = guard_q != cgr_pkg::G_MAIN;

   // backup oscillator, stopped when unused or halted
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bak_cnt_q <= 8'h00;
         bak_lvl_q <= 1'b0;
      end else if (!halt_mode) begin
         if (!want_bak && !backup_sel_q) begin
            bak_cnt_q <= 8'h00;
            bak_lvl_q <= 1'b0;
         end else if (bak_cnt_q == 8'(`CGR_BAK_HALF_CYC - 1)) begin
            bak_cnt_q <= 8'h00;
            bak_lvl_q <= ~bak_lvl_q;
         end else begin
            bak_cnt_q <= bak_cnt_q + 8'h01;
         end
      end
   end

   // switch only with the new source low
   // a dead main clock may sit high; ending that phase early is no runt
   always_comb begin
      sel_d = backup_sel_q;
      if (want_bak != backup_sel_q && !bak_lvl_q && (!flt_lvl_q || want_bak)) begin
         sel_d = want_bak;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         backup_sel_q <= 1'b0;
         src_clk_q <= 1'b0;
      end else if (!halt_mode) begin
         backup_sel_q <= sel_d;
         src_clk_q <= sel_d ? bak_lvl_q : flt_lvl_q;
      end
   end

   // half period in source edges, 1 normal, 2 to 16 slow
   // slow select and divider bits set the ratio
   assign half_m1 = sms_q ? 5'((5'h02 << dsel_q) - 5'h01) : 5'h00;

   always_comb begin
      cpu_d = cpu_clk_q;
      if (src_clk_q && !src_prev_q && 5'(pre_cnt_q) >= half_m1) begin
         cpu_d = ~cpu_clk_q;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         src_prev_q <= 1'b0;
         pre_cnt_q <= 4'h0;
         cpu_clk_q <= 1'b0;
         clk_out_q <= 1'b0;
      end else begin
         src_prev_q <= src_clk_q;
         cpu_clk_q <= cpu_d;
         // clock out gated by its enable
         clk_out_q <= cko_en_q & cpu_d;
         if (src_clk_q && !src_prev_q) begin
            if (5'(pre_cnt_q) >= half_m1) begin
               pre_cnt_q <= 4'h0;
            end else begin
               pre_cnt_q <= pre_cnt_q + 4'h1;
            end
         end
      end
   end

   // bus write and read decode
   assign wr_go = aw_full_q & w_full_q & ~s_axi_bvalid;
   assign wr_st = wr_go & w_strb_q[0] & (aw_addr_q[9:2] == `CGR_STATUS_IDX);
   assign wr_misc = wr_go & w_strb_q[0] & (aw_addr_q[9:2] == `CGR_MISC_IDX);
   assign rd_hs = s_axi_arvalid & s_axi_arready;
   assign rd_clr = rd_hs & (s_axi_araddr[9:2] == `CGR_STATUS_IDX);

   // reset events restore defaults, halt keeps them
   // enable and flag reset to zero
   // enable write lands but has no effect when guard off
   always_ff @(posedge aclk) begin
      if (!aresetn || rst_any) begin
         irq_en_q <= 1'b0;
      end else if (wr_st && !halt_mode) begin
         irq_en_q <= w_data_q[`CGR_B_IEN];
      end
   end

   // set wins over read clear, clear only after recovery
   always_ff @(posedge aclk) begin
      if (!aresetn || !guard_en_q || rst_any) begin
         bflag_q <= 1'b0;
      end else if (!halt_mode) begin
         if (backup_sel_q) begin
            bflag_q <= 1'b1;
         end else if (rd_clr && !want_bak) begin
            bflag_q <= 1'b0;
         end
      end
   end

   // with the detector off no event sets it
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         uv_flag_q <= 1'b0;
      end else if (rst_ev_uv && uv_en_q) begin
         uv_flag_q <= 1'b1;
      end else if (wr_st && !halt_mode && !w_data_q[`CGR_B_UV]) begin
         uv_flag_q <= 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn || rst_ev_uv) begin
         wdg_flag_q <= 1'b0;
      end else if (rst_ev_wdg) begin
         wdg_flag_q <= 1'b1;
      end else if (wr_st && !halt_mode && !w_data_q[`CGR_B_WDG]) begin
         wdg_flag_q <= 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn || rst_any) begin
         sms_q <= 1'b0;
         dsel_q <= 2'b00;
         cko_en_q <= 1'b0;
      end else if (wr_misc) begin
         sms_q <= w_data_q[`CGR_B_SMS];
         dsel_q <= {w_data_q[`CGR_B_DHI], w_data_q[`CGR_B_DLO]};
         cko_en_q <= w_data_q[`CGR_B_CKO];
      end
   end

   // reset flags read apart: wdg at bit 0, uv at bit 4
   always_comb begin
      status_byte = 8'h00;
      status_byte[`CGR_B_UV] = uv_flag_q;
      status_byte[`CGR_B_IEN] = irq_en_q;
      status_byte[`CGR_B_BFLAG] = bflag_q;
      status_byte[`CGR_B_WDG] = wdg_flag_q;
      misc_byte = 8'h00;
      misc_byte[`CGR_B_SMS] = sms_q;
      misc_byte[`CGR_B_DLO] = dsel_q[0];
      misc_byte[`CGR_B_DHI] = dsel_q[1];
      misc_byte[`CGR_B_CKO] = cko_en_q;
   end

   // flag, enable and open mask raise the request
   // halt blocks the wake, wait does not
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         guard_irq_q <= 1'b0;
         wait_wake_q <= 1'b0;
      end else begin
         guard_irq_q <= guard_en_q & bflag_q & irq_en_q & ~irq_mask & ~halt_mode;
         wait_wake_q <= guard_en_q & bflag_q & irq_en_q & ~halt_mode & wait_mode;
      end
   end

   // one write at a time; ready drops until the response is taken
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `CGR_RESP_OKAY;
         aw_full_q <= 1'b0;
         w_full_q <= 1'b0;
         aw_addr_q <= 10'h000;
         w_data_q <= 32'h00000000;
         w_strb_q <= 4'h0;
      end else begin
         if (!aw_full_q && !s_axi_bvalid) begin
            s_axi_awready <= 1'b1;
         end
         if (!w_full_q && !s_axi_bvalid) begin
            s_axi_wready <= 1'b1;
         end
         if (s_axi_awvalid && s_axi_awready) begin
            aw_full_q <= 1'b1;
            aw_addr_q <= s_axi_awaddr;
            s_axi_awready <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_full_q <= 1'b1;
            w_data_q <= s_axi_wdata;
            w_strb_q <= s_axi_wstrb;
            s_axi_wready <= 1'b0;
         end
         if (wr_go) begin
            aw_full_q <= 1'b0;
            w_full_q <= 1'b0;
            s_axi_bvalid <= 1'b1;
            if (aw_addr_q[9:2] == `CGR_STATUS_IDX || aw_addr_q[9:2] == `CGR_MISC_IDX) begin
               s_axi_bresp <= `CGR_RESP_OKAY;
            end else begin
               s_axi_bresp <= `CGR_RESP_SLVERR;
            end
         end
         if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h00000000;
         s_axi_rresp <= `CGR_RESP_OKAY;
         rd_st_q <= 1'b0;
      end else begin
         if (!s_axi_rvalid && !rd_hs) begin
            s_axi_arready <= 1'b1;
         end
         if (rd_hs) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            rd_st_q <= rd_clr;
            s_axi_rresp <= `CGR_RESP_OKAY;
            if (s_axi_araddr[9:2] == `CGR_STATUS_IDX) begin
               s_axi_rdata <= {24'h000000, status_byte};
            end else if (s_axi_araddr[9:2] == `CGR_MISC_IDX) begin
               s_axi_rdata <= {24'h000000, misc_byte};
            end else begin
               s_axi_rdata <= 32'h00000000;
               s_axi_rresp <= `CGR_RESP_SLVERR;
            end
         end
         if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   a_spike_filter: assert property (
      guard_en_q && $past(guard_en_q) && !halt_mode && $past(!halt_mode) && !$stable(flt_lvl_q)
      |-> $past(osc_in, 1) == flt_lvl_q && $past(osc_in, 2) == flt_lvl_q)
      else $error("filtered level changed on a spike");

   a_loss_backup: assert property (
      guard_q == cgr_pkg::G_MAIN && loss && guard_en_q && !halt_mode |=> guard_q == cgr_pkg::G_BACKUP)
      else $error("clock loss did not start backup");

   a_recover_main: assert property (
      guard_q == cgr_pkg::G_RECOVER && flt_edge && !loss && !halt_mode && guard_en_q
      && good_q == 4'(`CGR_RECOV_EDGES - 1) |=> guard_q == cgr_pkg::G_MAIN)
      else $error("recovered clock not taken back");

   a_flag_sets: assert property (
      backup_sel_q && guard_en_q && !halt_mode && !rst_any |=> bflag_q)
      else $error("backup flag not set");

   a_irq_cause: assert property (
      guard_irq_q |-> $past(bflag_q) && $past(irq_en_q) && !$past(irq_mask) && !$past(halt_mode))
      else $error("interrupt without its cause");

   a_halt_freeze: assert property (
      halt_mode && $past(halt_mode) && !$past(rst_any) |-> $stable(status_byte) && $stable(guard_q))
      else $error("status changed in halt");

   a_guard_off: assert property (
      !guard_en_q && strap_done_q |-> !bflag_q && !guard_irq_q ##1 !guard_irq_q)
      else $error("guard off but flag or interrupt active");

   a_reserved_zero: assert property (
      s_axi_rvalid && rd_st_q |-> s_axi_rdata[7:5] == 3'b000 && !s_axi_rdata[3])
      else $error("reserved status bits nonzero");

   a_uv_clears_wdg: assert property (
      rst_ev_uv |=> !wdg_flag_q)
      else $error("watchdog flag survived undervoltage reset");

   a_glitch_free: assert property (
      !$stable(backup_sel_q) |-> !src_clk_q && !$past(bak_lvl_q))
      else $error("source switched while high");

endmodule : cgr_top

// ### hdl/cgr_cfg.svh
// map, field and timing constants for the clock guard and reset flags
`ifndef CGR_CFG_SVH
`define CGR_CFG_SVH
`define CGR_CLK_NS 10
`define CGR_FILT_NS 40
`define CGR_FILT_CYC ((`CGR_FILT_NS + `CGR_CLK_NS - 1) / `CGR_CLK_NS)
`define CGR_LOSS_NS 2000
`define CGR_LOSS_CYC (`CGR_LOSS_NS / `CGR_CLK_NS)
`define CGR_BAK_HALF_NS 500
`define CGR_BAK_HALF_CYC (`CGR_BAK_HALF_NS / `CGR_CLK_NS)
`define CGR_RECOV_EDGES 8
`define CGR_STATUS_IDX 8'h25
`define CGR_MISC_IDX 8'h26
`define CGR_B_WDG 0
`define CGR_B_BFLAG 1
`define CGR_B_IEN 2
`define CGR_B_UV 4
`define CGR_B_SMS 0
`define CGR_B_DLO 1
`define CGR_B_DHI 2
`define CGR_B_CKO 3
`define CGR_RESP_OKAY 2'b00
`define CGR_RESP_SLVERR 2'b10
`endif

// ### hdl/cgr_pkg.sv
// types of the clock guard block
package cgr_pkg;
   typedef enum logic [1:0] {G_MAIN, G_BACKUP, G_RECOVER} cgr_guard_t;
endpackage : cgr_pkg

// ### verif/cgr_osc_model.sv
// behavioural main oscillator: runs, stalls or throws spikes
`timescale 1ns/1ps
module cgr_osc_model (
   // clock
   input wire logic aclk,
   // control: 0 stalled, 1 running, 2 spikes
   input wire logic [1:0] mode,
   input wire logic [7:0] half,
   // oscillator pin
   output logic osc_out
);
   logic [7:0] cnt_q = 8'h00;
   logic osc_q = 1'b0;
   logic wrap;
   assign wrap = (cnt_q + 8'h01) >= half;
   assign osc_out = osc_q;
   always @(posedge aclk) begin
      cnt_q <= wrap ? 8'h00 : cnt_q + 8'h01;
      case (mode)
         // a dead resonator freezes, so the filter sees no edge at all
         2'd0: osc_q <= osc_q;
         2'd1: if (wrap) osc_q <= ~osc_q;
         default: osc_q <= (cnt_q == 8'h00);
      endcase
   end
endmodule : cgr_osc_model

// ### verif/testbench.sv
// self-checking bench for the clock guard and reset flags
`timescale 1ns/1ps
`include "cgr_cfg.svh"
module testbench;
   localparam logic [9:0] A_ST = {`CGR_STATUS_IDX, 2'b00};
   localparam logic [9:0] A_MS = {`CGR_MISC_IDX, 2'b00};
   logic aclk = 1'b0, aresetn = 1'b0;
   logic [9:0] s_axi_awaddr = 10'h000, s_axi_araddr = 10'h000;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
   logic [3:0] s_axi_wstrb = 4'hf;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic osc_in, opt_guard_en = 1'b1, opt_uv_en = 1'b1;
   logic halt_mode = 1'b0, wait_mode = 1'b0, irq_mask = 1'b0;
   logic rst_ev_uv = 1'b0, rst_ev_wdg = 1'b0, rst_ev_ext = 1'b0;
   logic src_clk_q, cpu_clk_q, clk_out_q, backup_sel_q, guard_irq_q, wait_wake_q;
   logic [1:0] osc_mode = 2'd1;
   logic [7:0] osc_half = 8'h06;
   int fails = 0, n_checks = 0;
   logic [31:0] d;
   logic [1:0] r;
   int p;

   always #5 aclk = ~aclk;

   cgr_top u_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
      .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
      .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
      .s_axi_rready, .osc_in, .opt_guard_en, .opt_uv_en, .halt_mode, .wait_mode, .irq_mask,
      .rst_ev_uv, .rst_ev_wdg, .rst_ev_ext, .src_clk_q, .cpu_clk_q, .clk_out_q, .backup_sel_q,
      .guard_irq_q, .wait_wake_q);

   cgr_osc_model u_osc (.aclk, .mode(osc_mode), .half(osc_half), .osc_out(osc_in));

   task automatic stop_test;
      if (fails == 0 && n_checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : stop_test

   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      n_checks++;
      if (got !== exp) begin
         $display("[FAIL] %s expected %h seen %h", nm, exp, got);
         fails++;
      end
   endtask : chk

   task automatic tmo(input string nm);
      $display("[FAIL] %s expected handshake seen timeout", nm);
      fails++;
      stop_test();
   endtask : tmo

   task automatic cyc(input int n);
      repeat (n) @(posedge aclk);
   endtask : cyc

   // handshakes are judged at the falling edge, so the rising edge only carries updates
   task automatic wr(input logic [9:0] a, input logic [31:0] v, output logic [1:0] rsp);
      logic ta, tw, tb;
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= v;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      for (int n = 0; n < 50; n++) begin
         @(negedge aclk);
         ta = s_axi_awvalid && s_axi_awready;
         tw = s_axi_wvalid && s_axi_wready;
         tb = s_axi_bvalid && s_axi_bready;
         rsp = s_axi_bresp;
         @(posedge aclk);
         if (ta) s_axi_awvalid <= 1'b0;
         if (tw) s_axi_wvalid <= 1'b0;
         if (tb) begin
            s_axi_bready <= 1'b0;
            return;
         end
      end
      tmo("write");
   endtask : wr

   task automatic rd(input logic [9:0] a, output logic [31:0] v, output logic [1:0] rsp);
      logic ta, tr;
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      for (int n = 0; n < 50; n++) begin
         @(negedge aclk);
         ta = s_axi_arvalid && s_axi_arready;
         tr = s_axi_rvalid && s_axi_rready;
         v = s_axi_rdata;
         rsp = s_axi_rresp;
         @(posedge aclk);
         if (ta) s_axi_arvalid <= 1'b0;
         if (tr) begin
            s_axi_rready <= 1'b0;
            return;
         end
      end
      tmo("read");
   endtask : rd

   task automatic pulse(input int k);
      @(posedge aclk);
      if (k == 0) rst_ev_uv <= 1'b1; else if (k == 1) rst_ev_wdg <= 1'b1; else rst_ev_ext <= 1'b1;
      @(posedge aclk);
      {rst_ev_uv, rst_ev_wdg, rst_ev_ext} <= 3'b000;
   endtask : pulse

   task automatic wait_bsel(input logic v, input int bound);
      for (int n = 0; n < bound; n++) begin
         @(negedge aclk);
         if (backup_sel_q === v) return;
      end
      tmo("backup_sel_q");
   endtask : wait_bsel

   // cycles between the last two of three rising edges of the chosen clock
   task automatic period(input bit sel, output int pr);
      logic v, pv;
      int k, t1;
      k = 0;
      t1 = 0;
      pv = sel ? clk_out_q : cpu_clk_q;
      for (int n = 0; n < 2000; n++) begin
         @(negedge aclk);
         v = sel ? clk_out_q : cpu_clk_q;
         if (v === 1'b1 && pv === 1'b0) begin
            k++;
            if (k == 3) begin
               pr = n - t1;
               return;
            end
            t1 = n;
         end
         pv = v;
      end
      tmo("clock period");
   endtask : period

   // every cycle is watched: a spike train can come back to its start phase
   task automatic stable_src(input string nm, input int n);
      logic v, moved;
      @(negedge aclk);
      v = src_clk_q;
      moved = 1'b0;
      repeat (n) begin
         @(negedge aclk);
         if (src_clk_q !== v) moved = 1'b1;
      end
      chk(nm, 32'h0, {31'h0, moved});
      @(posedge aclk);
   endtask : stable_src

   task automatic do_reset(input logic g);
      aresetn <= 1'b0;
      opt_guard_en <= g;
      cyc(6);
      aresetn <= 1'b1;
      cyc(2);
   endtask : do_reset

   task automatic t_reset_vals;
      rd(A_ST, d, r);
      chk("status fixed bits", 32'h0, d & ~32'h11);
      rd(A_MS, d, r);
      chk("misc reset", 32'h0, d);
   endtask : t_reset_vals

   task automatic t_flags;
      pulse(1);
      rd(A_ST, d, r);
      chk("flags after wdg", 32'h01, d & 32'h11);
      pulse(0);
      rd(A_ST, d, r);
      chk("flags after uv", 32'h10, d);
      pulse(1);
      pulse(2);
      rd(A_ST, d, r);
      chk("uv kept", 32'h11, d);
      wr(A_ST, 32'hff, r);
      rd(A_ST, d, r);
      chk("write ones", 32'h15, d);
      wr(A_ST, 32'h04, r);
      rd(A_ST, d, r);
      chk("write zero clears", 32'h04, d);
      wr(10'h000, 32'hff, r);
      chk("unmapped bresp", `CGR_RESP_SLVERR, r);
      rd(10'h000, d, r);
      chk("unmapped rresp", `CGR_RESP_SLVERR, r);
      chk("unmapped rdata", 32'h0, d);
   endtask : t_flags

   task automatic t_prescale;
      logic [31:0] cfg [5] = '{32'h0, 32'h1, 32'h3, 32'h5, 32'h7};
      int exp [5] = '{24, 48, 96, 192, 384};
      for (int i = 0; i < 5; i++) begin
         wr(A_MS, cfg[i], r);
         period(1'b0, p);
         chk("cpu period", exp[i], p);
      end
      chk("clk_out off", 32'h0, {31'h0, clk_out_q});
      wr(A_MS, 32'h08, r);
      period(1'b1, p);
      chk("clk_out period", 24, p);
   endtask : t_prescale

   task automatic t_filter;
      osc_half <= 8'h0a;
      osc_mode <= 2'd2;
      cyc(10);
      stable_src("spikes filtered", 70);
      osc_half <= 8'h06;
      osc_mode <= 2'd1;
      cyc(40);
      osc_half <= 8'h02;
      cyc(10);
      stable_src("harmonic blocked", 70);
      osc_half <= 8'h06;
      period(1'b0, p);
      chk("clock resumes", 24, p);
   endtask : t_filter

   task automatic t_backup;
      wr(A_MS, 32'h0, r);
      wr(A_ST, 32'h04, r);
      osc_mode <= 2'd0;
      wait_bsel(1'b1, 400);
      rd(A_ST, d, r);
      chk("backup flag", 32'h06, d);
      cyc(3);
      chk("irq raised", 32'h1, {31'h0, guard_irq_q});
      irq_mask <= 1'b1;
      wait_mode <= 1'b1;
      cyc(3);
      chk("irq masked", 32'h0, {31'h0, guard_irq_q});
      chk("wait wake", 32'h1, {31'h0, wait_wake_q});
      irq_mask <= 1'b0;
      wait_mode <= 1'b0;
      halt_mode <= 1'b1;
      wr(A_ST, 32'h0, r);
      cyc(2);
      chk("irq in halt", 32'h0, {31'h0, guard_irq_q});
      stable_src("guard frozen", 120);
      halt_mode <= 1'b0;
      rd(A_ST, d, r);
      chk("status kept", 32'h06, d);
      cyc(2);
      chk("irq resumes", 32'h1, {31'h0, guard_irq_q});
      osc_mode <= 2'd1;
      wait_bsel(1'b0, 600);
      rd(A_ST, d, r);
      chk("flag until read", 32'h06, d);
      rd(A_ST, d, r);
      chk("flag read clear", 32'h04, d);
   endtask : t_backup

   task automatic t_guard_off;
      opt_uv_en <= 1'b0;
      do_reset(1'b0);
      wr(A_ST, 32'h04, r);
      osc_mode <= 2'd0;
      cyc(400);
      chk("no backup", 32'h0, {31'h0, backup_sel_q});
      rd(A_ST, d, r);
      chk("flag forced", 32'h0, d & 32'h02);
      chk("enable ignored", 32'h0, {31'h0, guard_irq_q});
      pulse(0);
      rd(A_ST, d, r);
      chk("uv flag with detector off", 32'h0, d & 32'h10);
   endtask : t_guard_off

   initial begin
      do_reset(1'b1);
      cyc(20);
      t_reset_vals();
      t_flags();
      t_prescale();
      t_filter();
      t_backup();
      t_guard_off();
      stop_test();
   end
endmodule : testbench
